//--- logic/rlmfc_pkg.sv
// rlmfc_pkg: constants, register map and carrier types of the led mode and fade control
// assumes a single 125 MHz clock and the register access strobes of the serial host engine
package rlmfc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_COLOR_FIRST = 8'h03;
  localparam logic [7:0] ADDR_COLOR_LAST = 8'h08;
  localparam logic [7:0] ADDR_SELECT_FIRST = 8'h09;
  localparam logic [7:0] ADDR_SELECT_LAST = 8'h0e;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COLOR_RESET = 8'h00;
  localparam logic [7:0] SELECT_RESET = 8'h00;

  // ==========================================================
  // mode_control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int DROPOUT_EXT_BIT = 5;
  localparam int TEMP_LIMIT_HI = 4;
  localparam int TEMP_LIMIT_LO = 3;
  localparam int FADE_RATE_HI = 2;
  localparam int FADE_RATE_LO = 0;
  localparam logic [1:0] MODE_OFF_REQ = 2'h0;
  localparam logic [1:0] MODE_NIGHT = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] MODE_REG_RESET = 2'h3;

  // ==========================================================
  // fault_status fields
  localparam int FS_REV_HI = 7;
  localparam int FS_REV_LO = 5;
  localparam int FS_SHORT_BIT = 4;
  localparam int FS_DROPOUT_BIT = 3;
  localparam int FS_TEMP_BIT = 2;
  localparam int FS_UVLO_TSD_BIT = 1;

  // ==========================================================
  // selection fields
  localparam int SEL_ON_BIT = 3;
  localparam int SEL_RED_BIT = 2;
  localparam int SEL_GREEN_BIT = 1;
  localparam int SEL_BLUE_BIT = 0;

  // ==========================================================
  // channels and fade arithmetic
  localparam int NUM_LEDS = 36;
  localparam int NUM_MODULES = 12;
  localparam int LEVEL_W = 12;
  localparam int NIGHT_SHIFT = 4;
  localparam int FADE_SHIFT = 5;
  localparam logic [8:0] SCALE_FULL = 9'h100;
  localparam logic [8:0] SCALE_MIN = 9'h040;
  localparam int SCALE_FRAC = 8;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FADE_TAU_MIN_NS = 31250000;
  localparam int FADE_TICK_CYC = FADE_TAU_MIN_NS / (CLK_PERIOD_NS * (1 << FADE_SHIFT));
  localparam int SCALE_STEP_NS = 1000000;
  localparam int SCALE_TICK_CYC = SCALE_STEP_NS / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_FADING_OFF = 2'b11
  } rlmfc_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rlmfc_req_type;

  typedef struct packed {
    logic short_detect;
    logic dropout_detect;
    logic [3:0] temp_over;
    logic uvlo_or_tsd;
  } rlmfc_sense_type;

endpackage

//--- logic/rlmfc_level_ram.sv
// rlmfc_level_ram: small level store, one word per led, registered read
// assumes one writer and one reader on a shared clock
`timescale 1ns/10ps

module rlmfc_level_ram #(
  parameter int DEPTH = 36,
  parameter int WIDTH = 12,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_reg
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end

endmodule // rlmfc_level_ram

//--- logic/rlmfc_fade_step.sv
// rlmfc_fade_step: one exponential step of a level toward its target
// assumes the caller applies it once per fade tick
`timescale 1ns/10ps

module rlmfc_fade_step
  import rlmfc_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] target,
  output logic [WIDTH-1:0] level_next
);

  logic [WIDTH-1:0] up_diff;
  logic [WIDTH-1:0] dn_diff;
  logic [WIDTH-1:0] up_inc;
  logic [WIDTH-1:0] dn_inc;

  assign up_diff = target - level;
  assign dn_diff = level - target;
  // a fixed fraction of the gap keeps settling time independent of start and end
  // never less than one step, so the level lands exactly on target
  assign up_inc = ((up_diff >> FADE_SHIFT) == '0) ? WIDTH'(1) : (up_diff >> FADE_SHIFT);
  assign dn_inc = ((dn_diff >> FADE_SHIFT) == '0) ? WIDTH'(1) : (dn_diff >> FADE_SHIFT);
  assign level_next = (target > level) ? level + up_inc :
                      (target < level) ? level - dn_inc : level;

endmodule // rlmfc_fade_step

//--- logic/rlmfc_top.sv
// rlmfc_top: operating mode, register file, 36 fade engines and global current scale
// assumes the serial host engine delivers single-cycle read and write strobes,
// and analog sense flags arrive synchronous to clk
`timescale 1ns/10ps

module rlmfc_top
  import rlmfc_pkg::*;
#(
  parameter int FADE_TICK = FADE_TICK_CYC,
  parameter int SCALE_TICK = SCALE_TICK_CYC,
  parameter logic [2:0] DIE_REVISION = 3'h1 // value is arbitrary
) (
  input wire logic clk,
  input wire logic sys_rst,
  input rlmfc_req_type reg_req,
  input rlmfc_sense_type sense,
  output logic [7:0] reg_rdata_reg,
  output logic [5:0] led_index_reg,
  output logic [LEVEL_W-1:0] led_level_reg,
  output logic led_valid_reg,
  output logic sinks_active_reg
);

  // ==========================================================
  // register file
  logic [7:0] mode_control_reg;
  logic [7:0] color_reg [6];
  logic [7:0] select_reg [6];
  rlmfc_state_type state_reg;
  rlmfc_state_type state_next;

  logic wr_mode;
  logic wr_color;
  logic wr_select;
  logic [1:0] wr_mode_field;
  logic reg_reset;
  logic [2:0] color_idx;
  logic [2:0] select_idx;
  logic [7:0] fault_status;
  logic [7:0] rdata_next;
  logic temp_over_sel;
  logic limiting;

  assign wr_mode = reg_req.wr && (reg_req.addr == ADDR_MODE_CONTROL);
  assign wr_color = reg_req.wr && (reg_req.addr >= ADDR_COLOR_FIRST)
                    && (reg_req.addr <= ADDR_COLOR_LAST);
  assign wr_select = reg_req.wr && (reg_req.addr >= ADDR_SELECT_FIRST)
                     && (reg_req.addr <= ADDR_SELECT_LAST);
  assign color_idx = 3'(reg_req.addr - ADDR_COLOR_FIRST);
  assign select_idx = 3'(reg_req.addr - ADDR_SELECT_FIRST);
  assign wr_mode_field = reg_req.wdata[MODE_HI:MODE_LO];
  assign reg_reset = wr_mode && (wr_mode_field == MODE_REG_RESET);

  always_ff @(posedge clk) begin
    if (sys_rst || reg_reset) begin
      for (int i = 0; i < 6; i++) begin
        color_reg[i] <= COLOR_RESET;
        select_reg[i] <= SELECT_RESET;
      end
    end else if (wr_color) begin
      color_reg[color_idx] <= reg_req.wdata;
    end else if (wr_select) begin
      select_reg[select_idx] <= reg_req.wdata;
    end
  end

  // reset code acts once, never stored
  always_ff @(posedge clk) begin
    if (sys_rst || reg_reset) begin
      mode_control_reg <= MODE_CONTROL_RESET;
    end else if (wr_mode) begin
      mode_control_reg <= reg_req.wdata;
    end
  end

  always_comb begin
    fault_status = '0;
    fault_status[FS_REV_HI:FS_REV_LO] = DIE_REVISION;
    fault_status[FS_SHORT_BIT] = sense.short_detect;
    fault_status[FS_DROPOUT_BIT] = sense.dropout_detect;
    fault_status[FS_TEMP_BIT] = temp_over_sel;
    fault_status[FS_UVLO_TSD_BIT] = sense.uvlo_or_tsd;
  end

  always_comb begin
    if (reg_req.addr == ADDR_FAULT_STATUS) begin
      rdata_next = fault_status;
    end else if (reg_req.addr == ADDR_MODE_CONTROL) begin
      rdata_next = mode_control_reg;
    end else if ((reg_req.addr >= ADDR_COLOR_FIRST) && (reg_req.addr <= ADDR_COLOR_LAST)) begin
      rdata_next = color_reg[color_idx];
    end else if ((reg_req.addr >= ADDR_SELECT_FIRST) && (reg_req.addr <= ADDR_SELECT_LAST)) begin
      rdata_next = select_reg[select_idx];
    end else begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // mode state machine
  logic sweep_end;
  logic sweep_all_zero;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUTDOWN: begin
        if (wr_mode && ((wr_mode_field == MODE_NORMAL) || (wr_mode_field == MODE_NIGHT))) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (reg_reset) begin
          state_next = ST_SHUTDOWN;
        end else if (wr_mode && (wr_mode_field == MODE_OFF_REQ)) begin
          state_next = ST_FADING_OFF;
        end
      end
      ST_FADING_OFF: begin
        if (reg_reset) begin
          state_next = ST_SHUTDOWN;
        end else if (wr_mode && ((wr_mode_field == MODE_NORMAL)
                     || (wr_mode_field == MODE_NIGHT))) begin
          state_next = ST_ACTIVE;
        // shutdown once every led is zero
        end else if (sweep_end && sweep_all_zero) begin
          state_next = ST_SHUTDOWN;
        end
      end
      default: state_next = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // fade tick divider
  logic [31:0] fade_cnt_reg;
  logic [31:0] fade_period;
  logic fade_tick;
  logic tick_pending_reg;

  // one rate for all, takes effect at once
  assign fade_period = 32'(FADE_TICK) << mode_control_reg[FADE_RATE_HI:FADE_RATE_LO];
  assign fade_tick = (fade_cnt_reg >= fade_period - 32'd1);

  always_ff @(posedge clk) begin
    if (sys_rst || fade_tick) begin
      fade_cnt_reg <= '0;
    end else begin
      fade_cnt_reg <= fade_cnt_reg + 32'd1;
    end
  end

  // ==========================================================
  // channel sweep: read in stage 0, step and write back in stage 1
  logic [5:0] ptr_reg;
  logic [1:0] comp_reg;
  logic [3:0] mod_reg;
  logic [5:0] ptr_d_reg;
  logic [LEVEL_W-1:0] target_d_reg;
  logic step_en_reg;
  logic step_d_reg;
  logic step_now;
  logic ptr_last;
  logic [3:0] sel_field;
  logic [7:0] code;
  logic [LEVEL_W-1:0] target;
  logic [LEVEL_W-1:0] level_rd;
  logic [LEVEL_W-1:0] level_step;
  logic [LEVEL_W-1:0] level_wr;
  logic zero_seen_reg;

  assign ptr_last = (ptr_reg == 6'(NUM_LEDS - 1));
  assign step_now = (ptr_reg == '0) ? tick_pending_reg : step_en_reg;

  // even module takes the upper nibble
  assign sel_field = mod_reg[0] ? select_reg[mod_reg[3:1]][3:0]
                                : select_reg[mod_reg[3:1]][7:4];

  // each component picks colour zero or one on its own
  function automatic logic [7:0] pick_code(input logic [3:0] field, input logic [1:0] comp);
    logic use_one;
    use_one = (comp == 2'd0) ? field[SEL_RED_BIT] :
              (comp == 2'd1) ? field[SEL_GREEN_BIT] : field[SEL_BLUE_BIT];
    return color_reg[{1'b0, comp} + (use_one ? 3'd3 : 3'd0)];
  endfunction

  assign code = pick_code(sel_field, comp_reg);
  // code times sixteen fine steps; night uses the code directly
  assign target = (state_reg != ST_ACTIVE) || !sel_field[SEL_ON_BIT] ? '0 :
                  (mode_control_reg[MODE_HI:MODE_LO] == MODE_NIGHT) ? LEVEL_W'(code) :
                  LEVEL_W'({code, 4'h0});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_reg <= '0;
      comp_reg <= '0;
      mod_reg <= '0;
      step_en_reg <= 1'b0;
      tick_pending_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_last ? '0 : ptr_reg + 6'd1;
      comp_reg <= (comp_reg == 2'd2 || ptr_last) ? '0 : comp_reg + 2'd1;
      mod_reg <= ptr_last ? '0 : (comp_reg == 2'd2) ? mod_reg + 4'd1 : mod_reg;
      step_en_reg <= step_now;
      // a tick landing on the consuming cycle is kept for the next sweep
      tick_pending_reg <= fade_tick || (tick_pending_reg && (ptr_reg != '0));
    end
  end

  always_ff @(posedge clk) begin
    ptr_d_reg <= ptr_reg;
    target_d_reg <= target;
    step_d_reg <= step_now;
  end

  rlmfc_level_ram #(
    .DEPTH(NUM_LEDS),
    .WIDTH(LEVEL_W),
    .AW(6)
  ) u_level_ram (
    .clk(clk),
    .wr_en(1'b1),
    .wr_addr(ptr_d_reg),
    .wr_data(level_wr),
    .rd_addr(ptr_reg),
    .rd_data_reg(level_rd)
  );

  rlmfc_fade_step #(
    .WIDTH(LEVEL_W)
  ) u_fade_step (
    .level(level_rd),
    .target(target_d_reg),
    .level_next(level_step)
  );

  // every engine steps toward its target on the sweep after each fade tick
  // levels held at zero in shutdown
  assign level_wr = (state_reg == ST_SHUTDOWN) ? '0 : step_d_reg ? level_step : level_rd;

  assign sweep_end = (ptr_d_reg == 6'(NUM_LEDS - 1));
  assign sweep_all_zero = zero_seen_reg && (level_wr == '0);

  always_ff @(posedge clk) begin
    if (sys_rst || sweep_end) begin
      zero_seen_reg <= 1'b1;
    end else if (level_wr != '0) begin
      zero_seen_reg <= 1'b0;
    end
  end

  // ==========================================================
  // global current scale
  logic [8:0] scale_reg;
  logic [31:0] scale_cnt_reg;
  logic scale_tick;
  logic [LEVEL_W+8:0] scaled;

  assign temp_over_sel = sense.temp_over[mode_control_reg[TEMP_LIMIT_HI:TEMP_LIMIT_LO]];
  assign limiting = temp_over_sel
                    || (mode_control_reg[DROPOUT_EXT_BIT] && sense.dropout_detect);
  assign scale_tick = (scale_cnt_reg >= 32'(SCALE_TICK) - 32'd1);

  always_ff @(posedge clk) begin
    if (sys_rst || scale_tick) begin
      scale_cnt_reg <= '0;
    end else begin
      scale_cnt_reg <= scale_cnt_reg + 32'd1;
    end
  end

  // drop while limiting, creep back after
  always_ff @(posedge clk) begin
    if (sys_rst || (state_reg == ST_SHUTDOWN)) begin
      scale_reg <= SCALE_FULL;
    end else if (scale_tick && limiting && (scale_reg > SCALE_MIN)) begin
      scale_reg <= scale_reg - 9'd1;
    end else if (scale_tick && !limiting && (scale_reg < SCALE_FULL)) begin
      scale_reg <= scale_reg + 9'd1;
    end
  end

  assign scaled = level_wr * scale_reg;

  // ==========================================================
  // drive to the sink sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_index_reg <= '0;
      led_level_reg <= '0;
      led_valid_reg <= 1'b0;
      sinks_active_reg <= 1'b0;
    end else begin
      led_index_reg <= ptr_d_reg;
      led_level_reg <= scaled[SCALE_FRAC +: LEVEL_W];
      led_valid_reg <= 1'b1;
      sinks_active_reg <= (state_reg != ST_SHUTDOWN);
    end
  end

endmodule // rlmfc_top

//--- testbench/rlmfc_top_monitor.sv
// rlmfc_top_monitor: port assertions of the led mode and fade control
// assumes bind onto rlmfc_top, one clock domain
`timescale 1ns/10ps

module rlmfc_top_monitor
  import rlmfc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input rlmfc_req_type reg_req,
  input rlmfc_sense_type sense,
  input wire logic [7:0] reg_rdata_reg,
  input wire logic [5:0] led_index_reg,
  input wire logic [LEVEL_W-1:0] led_level_reg,
  input wire logic led_valid_reg,
  input wire logic sinks_active_reg
);
  // ==========================================================
  // decode
  wire ctl_wr = reg_req.wr && reg_req.addr == ADDR_MODE_CONTROL;
  wire [1:0] wmode = reg_req.wdata[MODE_HI:MODE_LO];
  wire fs_rd = reg_req.rd && reg_req.addr == ADDR_FAULT_STATUS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // properties
  property p_rst_quiet;
    disable iff (1'b0) sys_rst |=> !sinks_active_reg && led_level_reg == '0 && !led_valid_reg;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle in reset");
  property p_normal_on;
    ctl_wr && wmode == MODE_NORMAL |-> ##2 sinks_active_reg;
  endproperty
  a_normal_on: assert property (p_normal_on) else $error("normal mode not entered");
  property p_regreset_off;
    ctl_wr && wmode == MODE_REG_RESET |-> ##2 !sinks_active_reg;
  endproperty
  a_regreset_off: assert property (p_regreset_off) else $error("register reset kept sinks");
  property p_off_idle;
    ctl_wr && wmode == MODE_OFF_REQ && !sinks_active_reg |=> !sinks_active_reg [*2];
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("off request woke the sinks");
  // output register may lag a few cycles behind the state
  property p_idle_dark;
    !sinks_active_reg [*4] |-> led_level_reg == '0;
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("current while shut down");
  property p_index_wrap;
    led_valid_reg && $past(led_valid_reg) |=>
      led_index_reg == (($past(led_index_reg) == 6'd35) ? 6'd0 : $past(led_index_reg) + 6'd1);
  endproperty
  a_index_wrap: assert property (p_index_wrap) else $error("led index out of order");
  property p_unmapped_rd;
    reg_req.rd && reg_req.addr >= 8'h0f |=> reg_rdata_reg == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_fault_rd;
    fs_rd && $stable(sense) |=> reg_rdata_reg[FS_SHORT_BIT] == $past(sense.short_detect)
      && reg_rdata_reg[FS_DROPOUT_BIT] == $past(sense.dropout_detect);
  endproperty
  a_fault_rd: assert property (p_fault_rd) else $error("fault status mismatch");

  c_wake: cover property ($rose(sinks_active_reg));
  c_sleep: cover property ($fell(sinks_active_reg));
  c_fault: cover property (fs_rd);
endmodule // rlmfc_top_monitor

bind rlmfc_top rlmfc_top_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
  .sense(sense), .reg_rdata_reg(reg_rdata_reg), .led_index_reg(led_index_reg),
  .led_level_reg(led_level_reg), .led_valid_reg(led_valid_reg),
  .sinks_active_reg(sinks_active_reg));

//--- testbench/rlmfc_host_model.sv
// rlmfc_host_model: host side of the register port, single byte accesses
// assumes requests launched 1 ns after the rising edge
`timescale 1ns/10ps

module rlmfc_host_model
  import rlmfc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output rlmfc_req_type reg_req
);
  initial reg_req = '0;

  // idle fields show inverted data so stale values never match
  // writes accepted in any mode
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule // rlmfc_host_model

//--- testbench/tb_rlmfc_top.sv
// tb_rlmfc_top: random presets, mode sequence, scaling and status checks
// assumes short fade and scale ticks so ramps settle within the run
`timescale 1ns/10ps

module tb_rlmfc_top;
  import rlmfc_pkg::*;
  localparam int LIM = 40000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rlmfc_req_type reg_req;
  rlmfc_sense_type sense = '0;
  logic [7:0] reg_rdata_reg;
  logic [5:0] led_index_reg;
  logic [LEVEL_W-1:0] led_level_reg;
  logic led_valid_reg;
  logic sinks_active_reg;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] col [6];
  logic [7:0] sel [6];
  logic [31:0] seed_val;

  always #4 clk = ~clk;

  // fade tick above one sweep so every led steps once per tick
  rlmfc_top #(.FADE_TICK(40), .SCALE_TICK(8), .DIE_REVISION(3'h1)) u_dut (.clk(clk),
    .sys_rst(sys_rst), .reg_req(reg_req), .sense(sense), .reg_rdata_reg(reg_rdata_reg),
    .led_index_reg(led_index_reg), .led_level_reg(led_level_reg),
    .led_valid_reg(led_valid_reg), .sinks_active_reg(sinks_active_reg));
  rlmfc_host_model u_host (.clk(clk), .rdata(reg_rdata_reg), .reg_req(reg_req));

  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    check(nm, 18'(d), 18'(exp));
  endtask

  function automatic logic [11:0] want(input int led, input logic night);
    logic [3:0] nib;
    logic [7:0] code;
    nib = ((led / 3) % 2 == 0) ? sel[led / 6][7:4] : sel[led / 6][3:0];
    code = col[(nib[2 - led % 3] ? 3 : 0) + led % 3];
    if (!nib[3])
      return 12'h000;
    return night ? {4'h0, code} : {code, 4'h0};
  endfunction

  // index is compared too, so a timeout can never pass
  task automatic wait_lvl(input int led, input logic [11:0] exp);
    int i;
    for (i = 0; i < LIM; i++) begin
      @(posedge clk);
      #1;
      if (led_index_reg === 6'(led) && led_level_reg === exp)
        break;
    end
    check("led level", {led_index_reg, led_level_reg}, {6'(led), exp});
    if (i >= LIM)
      stop_test();
  endtask

  task automatic sweep(input logic night);
    for (int led = 0; led < NUM_LEDS; led++)
      wait_lvl(led, want(led, night));
  endtask

  task automatic scale_case(input logic [7:0] mc, input logic [6:0] s, input logic [7:0] fs);
    u_host.wr(ADDR_MODE_CONTROL, mc);
    sense = s;
    wait_lvl(3, want(3, 1'b0) >> 2);
    rd_chk("fault", ADDR_FAULT_STATUS, fs);
    sense = '0;
    wait_lvl(3, want(3, 1'b0));
  endtask

  // ==========================================================
  // sequence
  initial begin
    seed_val = $urandom(32'h013d);
    for (int i = 0; i < 6; i++) begin
      col[i] = 8'($urandom) | 8'h10;
      sel[i] = 8'($urandom);
    end
    col[0] = 8'hff;
    sel[0] = 8'h8f;
    sel[1] = 8'hd0;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check("active", 18'(sinks_active_reg), 18'h0);
    rd_chk("mode", ADDR_MODE_CONTROL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      u_host.wr(ADDR_COLOR_FIRST + 8'(i), col[i]);
      u_host.wr(ADDR_SELECT_FIRST + 8'(i), sel[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk("colour", ADDR_COLOR_FIRST + 8'(i), col[i]);
      rd_chk("select", ADDR_SELECT_FIRST + 8'(i), sel[i]);
    end
    check("active", 18'(sinks_active_reg), 18'h0);
    u_host.wr(ADDR_MODE_CONTROL, 8'h07);
    rd_chk("mode", ADDR_MODE_CONTROL, 8'h07);
    u_host.wr(ADDR_MODE_CONTROL, 8'h80);
    sweep(1'b0);
    u_host.wr(ADDR_MODE_CONTROL, 8'h40);
    repeat (400) @(posedge clk);
    #1;
    sel[0] = sel[0] ^ 8'h70;
    u_host.wr(ADDR_SELECT_FIRST, sel[0]);
    sweep(1'b1);
    scale_case(8'ha0, 7'b1100000, 8'h38);
    scale_case(8'h90, 7'b0001000, 8'h24);
    u_host.wr(ADDR_MODE_CONTROL, 8'h00);
    check("active", 18'(sinks_active_reg), 18'h1);
    for (int n = 0; n < LIM && sinks_active_reg !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check("active", 18'(sinks_active_reg), 18'h0);
    rd_chk("colour", ADDR_COLOR_FIRST, col[0]);
    sense = 7'b0000001;
    rd_chk("fault", ADDR_FAULT_STATUS, 8'h22);
    sense = '0;
    for (int r = 0; r < 8; r++) begin
      u_host.wr(ADDR_MODE_CONTROL, {5'h10, 3'(r)});
      rd_chk("rate", ADDR_MODE_CONTROL, {5'h10, 3'(r)});
    end
    u_host.wr(ADDR_MODE_CONTROL, 8'hc5);
    rd_chk("mode", ADDR_MODE_CONTROL, 8'h00);
    rd_chk("colour", ADDR_COLOR_FIRST, 8'h00);
    check("active", 18'(sinks_active_reg), 18'h0);
    u_host.wr(ADDR_FAULT_STATUS, 8'hff);
    rd_chk("fault", ADDR_FAULT_STATUS, 8'h20);
    rd_chk("unmapped", 8'h0f, 8'h00);
    stop_test();
  end
endmodule // tb_rlmfc_top
